// ===== design/nmp_pkg.sv
// package: opcode fields, reset values and carriers for the nibble move executor
package nmp_pkg;

    // ==========================================================
    // widths
    localparam int NMP_NIB_W = 4;
    localparam int NMP_ADDR_W = 7;
    localparam int NMP_INSTR_W = 16;
    localparam int NMP_RAM_DEPTH = 128;

    // ==========================================================
    // opcode prefixes, 16-bit forms sit in instr[15:7]
    localparam logic [8:0] NMP_OP_STORE_ACCUM = 9'h0b3; // 0 1 0 1 1 0 0 1 1
    localparam logic [8:0] NMP_OP_RD_BIDIR1 = 9'h0b6;   // 0 1 0 1 1 0 1 1 0
    localparam logic [8:0] NMP_OP_RD_BIDIR2 = 9'h0b7;   // 0 1 0 1 1 0 1 1 1
    localparam logic [8:0] NMP_OP_RD_INPUT1 = 9'h096;   // 0 1 0 0 1 0 1 1 0
    localparam logic [8:0] NMP_OP_RD_INPUT2 = 9'h097;   // 0 1 0 0 1 0 1 1 1
    localparam logic [8:0] NMP_OP_WR_BIDIR1 = 9'h0b4;   // 0 1 0 1 1 0 1 0 0
    localparam logic [8:0] NMP_OP_WR_BIDIR2 = 9'h0b5;   // 0 1 0 1 1 0 1 0 1
    // 15-bit forms sit right aligned in instr[14:0], bit 15 must be zero
    localparam logic [7:0] NMP_OP_WR_LED = 8'h5c;       // 0 1 0 1 1 1 0 0
    localparam logic [3:0] NMP_OP_WREG = 4'hf;          // 1 1 1 1, instr[14:11]
    // immediate form is 16 bits: instr[15:11]
    localparam logic [4:0] NMP_OP_IMM = 5'h17;          // 1 0 1 1 1

    // ==========================================================
    // field positions
    localparam int NMP_ADDR_LSB = 0;
    localparam int NMP_NIB_LSB = 7;
    localparam int NMP_P9_LSB = 7;
    localparam int NMP_P8_LSB = 7;
    localparam int NMP_WREG_LSB = 7;
    localparam int NMP_IMM_LSB = 11;

    // working registers live in the lowest page of data ram
    localparam logic [6:0] NMP_WREG_BASE = 7'h00;

    // ==========================================================
    // reset values
    localparam logic [3:0] NMP_DIR_RESET = 4'hf;   // all pins inputs
    localparam logic [3:0] NMP_NIB_RESET = 4'h0;

    // ==========================================================
    // decoded operation, one-hot
    typedef enum logic [9:0] {
        NMP_DEC_NONE = 10'h001,
        NMP_DEC_STORE_ACCUM = 10'h002,
        NMP_DEC_RD_PORT = 10'h004,
        NMP_DEC_WREG = 10'h008,
        NMP_DEC_IMM = 10'h010,
        NMP_DEC_WR_BIDIR1 = 10'h020,
        NMP_DEC_WR_BIDIR2 = 10'h040,
        NMP_DEC_WR_LED = 10'h080,
        NMP_DEC_RSVD0 = 10'h100,
        NMP_DEC_RSVD1 = 10'h200
    } nmp_dec_e;

    // one two-way port as seen from the core
    typedef struct packed {
        logic [3:0] dout;
        logic [3:0] oe;
    } nmp_bidir_s;

    // one issued instruction
    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } nmp_instr_s;

endpackage

// ===== design/nmp_exec.sv
// nibble move and port i/o execute unit of a 4-bit core
`timescale 1ns/1ps
// ==========================================================
// What this block does
// RULE_01: store accumulator nibble into addressed ram in one cycle
// RULE_02: read first two-way port into ram and accumulator, update zero flag
// RULE_03: read second two-way port into ram and accumulator, update zero flag
// RULE_04: read first input port into ram and accumulator, update zero flag
// RULE_05: read second input port into ram and accumulator, update zero flag
// RULE_06: copy selected working register into addressed ram in one cycle
// RULE_07: write immediate nibble into addressed ram
// RULE_08: copy addressed ram nibble to first two-way port latch
// RULE_09: copy addressed ram nibble to second two-way port latch
// RULE_10: copy addressed ram nibble to led port latch
// RULE_11: first two-way port pins are inputs after reset, mask all ones
// RULE_12: port reads set zero flag on zero nibble, other moves keep it
module nmp_exec (
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire nmp_pkg::nmp_instr_s instr_i,
    input wire logic [3:0] bidir_port_first_pin_i,
    input wire logic [3:0] bidir_port_second_pin_i,
    input wire logic [3:0] input_port_first_pin_i,
    input wire logic [3:0] input_port_second_pin_i,
    input wire logic first_port_dir_wr_i,
    input wire logic [3:0] first_port_dir_i,
    input wire logic second_port_dir_wr_i,
    input wire logic [3:0] second_port_dir_i,
    output nmp_pkg::nmp_bidir_s bidir_port_first_o,
    output nmp_pkg::nmp_bidir_s bidir_port_second_o,
    output logic [3:0] led_output_port_o,
    output logic [3:0] arith_result_reg_o,
    output logic result_null_flag_o,
    output logic exec_done_o
);
    import nmp_pkg::*;

    // ==========================================================
    // pin synchronisers; the first stage feeds only the second
    logic [3:0] sync1_ff [4];
    logic [3:0] sync2_ff [4];
    logic [3:0] pin_raw [4];
    assign pin_raw[0] = bidir_port_first_pin_i;
    assign pin_raw[1] = bidir_port_second_pin_i;
    assign pin_raw[2] = input_port_first_pin_i;
    assign pin_raw[3] = input_port_second_pin_i;

    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : g_sync
            always_ff @(posedge clock_i or negedge rst_b_i) begin
                if (!rst_b_i) begin
                    sync1_ff[g] <= NMP_NIB_RESET;
                    sync2_ff[g] <= NMP_NIB_RESET;
                end else begin
                    sync1_ff[g] <= pin_raw[g];
                    sync2_ff[g] <= sync1_ff[g];
                end
            end
        end
    endgenerate

    // ==========================================================
    // decode
    logic [15:0] word;
    logic [6:0] addr;
    logic [8:0] pfx9;
    logic [7:0] pfx8;
    nmp_dec_e dec;
    logic [3:0] port_nib;
    assign word = instr_i.word;
    assign addr = word[NMP_ADDR_LSB +: NMP_ADDR_W];
    assign pfx9 = word[NMP_P9_LSB +: 9];
    assign pfx8 = word[NMP_P8_LSB +: 8];

    // ==========================================================
    // opcode hits; the 9-bit prefixes are mutually exclusive
    logic short_form;
    logic hit_store_accum;
    logic hit_rd_bidir1;
    logic hit_rd_bidir2;
    logic hit_rd_input1;
    logic hit_rd_input2;
    logic hit_wr_bidir1;
    logic hit_wr_bidir2;
    logic hit_wr_led;
    logic hit_wreg;
    logic hit_imm;
    // 15-bit forms are right aligned, so bit 15 has to be clear
    assign short_form = !word[15];
    assign hit_store_accum = instr_i.valid && (pfx9 == NMP_OP_STORE_ACCUM); // RULE_01
    assign hit_rd_bidir1 = instr_i.valid && (pfx9 == NMP_OP_RD_BIDIR1); // RULE_02
    assign hit_rd_bidir2 = instr_i.valid && (pfx9 == NMP_OP_RD_BIDIR2); // RULE_03
    assign hit_rd_input1 = instr_i.valid && (pfx9 == NMP_OP_RD_INPUT1); // RULE_04
    assign hit_rd_input2 = instr_i.valid && (pfx9 == NMP_OP_RD_INPUT2); // RULE_05
    assign hit_wr_bidir1 = instr_i.valid && (pfx9 == NMP_OP_WR_BIDIR1); // RULE_08
    assign hit_wr_bidir2 = instr_i.valid && (pfx9 == NMP_OP_WR_BIDIR2); // RULE_09
    assign hit_wr_led = instr_i.valid && short_form && (pfx8 == NMP_OP_WR_LED); // RULE_10
    assign hit_wreg = instr_i.valid && short_form && (word[14:11] == NMP_OP_WREG); // RULE_06
    assign hit_imm = instr_i.valid && (word[15:11] == NMP_OP_IMM); // RULE_07

    // ==========================================================
    // port read select, one-hot so the mux stays a flat and-or
    logic [3:0] rd_sel;
    logic rd_any;
    assign rd_sel = {hit_rd_input2, hit_rd_input1, hit_rd_bidir2, hit_rd_bidir1};
    assign rd_any = |rd_sel;

    always_comb begin
        port_nib = NMP_NIB_RESET;
        for (int k = 0; k < 4; k++) begin
            if (rd_sel[k]) begin
                port_nib = sync2_ff[k];
            end
        end
    end

    // ==========================================================
    // priority: 9-bit prefixes, then led, then working register, then immediate
    always_comb begin
        dec = NMP_DEC_NONE;
        if (hit_store_accum) begin
            dec = NMP_DEC_STORE_ACCUM;
        end else if (rd_any) begin
            dec = NMP_DEC_RD_PORT;
        end else if (hit_wr_bidir1) begin
            dec = NMP_DEC_WR_BIDIR1;
        end else if (hit_wr_bidir2) begin
            dec = NMP_DEC_WR_BIDIR2;
        end else if (hit_wr_led) begin
            dec = NMP_DEC_WR_LED;
        end else if (hit_wreg) begin
            dec = NMP_DEC_WREG;
        end else if (hit_imm) begin
            dec = NMP_DEC_IMM;
        end
    end

    // ==========================================================
    // data ram, combinational read so every move finishes in one cycle
    logic [3:0] ram [NMP_RAM_DEPTH];
    logic [3:0] ram_rd;
    logic [3:0] wreg_rd;
    logic [6:0] wreg_addr;
    logic ram_we;
    logic [3:0] ram_wd;
    assign ram_rd = ram[addr];
    assign wreg_addr = NMP_WREG_BASE | {3'h0, word[NMP_WREG_LSB +: 4]};
    assign wreg_rd = ram[wreg_addr];

    // ==========================================================
    // ram write port: one source per decoded move
    always_comb begin
        ram_we = 1'b0;
        ram_wd = NMP_NIB_RESET;
        unique case (dec)
            NMP_DEC_STORE_ACCUM: begin
                ram_we = 1'b1;
                ram_wd = arith_result_reg_o; // RULE_01
            end
            NMP_DEC_RD_PORT: begin
                ram_we = 1'b1;
                ram_wd = port_nib; // RULE_02
            end
            NMP_DEC_WREG: begin
                ram_we = 1'b1;
                ram_wd = wreg_rd; // RULE_06
            end
            NMP_DEC_IMM: begin
                ram_we = 1'b1;
                ram_wd = word[NMP_IMM_LSB - 4 +: 4]; // RULE_07
            end
            default: begin
                ram_we = 1'b0;
            end
        endcase
    end

    // no reset on the array: contents are undefined until software writes
    always_ff @(posedge clock_i) begin
        if (ram_we) begin
            ram[addr] <= ram_wd;
        end
    end

    // ==========================================================
    // accumulator: only port reads load it
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            arith_result_reg_o <= NMP_NIB_RESET;
        end else if (dec == NMP_DEC_RD_PORT) begin
            arith_result_reg_o <= port_nib; // RULE_02
        end
    end

    // ==========================================================
    // zero flag: the other moves must leave it alone
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            result_null_flag_o <= 1'b0;
        end else if (dec == NMP_DEC_RD_PORT) begin
            result_null_flag_o <= (port_nib == 4'h0); // RULE_12
        end
    end

    // ==========================================================
    // first two-way port output latch
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bidir_port_first_o.dout <= NMP_NIB_RESET;
        end else if (dec == NMP_DEC_WR_BIDIR1) begin
            bidir_port_first_o.dout <= ram_rd; // RULE_08
        end
    end

    // ==========================================================
    // second two-way port output latch
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bidir_port_second_o.dout <= NMP_NIB_RESET;
        end else if (dec == NMP_DEC_WR_BIDIR2) begin
            bidir_port_second_o.dout <= ram_rd; // RULE_09
        end
    end

    // ==========================================================
    // led port latch; the pads carry the sink current, not this flop
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            led_output_port_o <= NMP_NIB_RESET;
        end else if (dec == NMP_DEC_WR_LED) begin
            led_output_port_o <= ram_rd; // RULE_10
        end
    end

    // ==========================================================
    // first port direction mask (1 = input), held inverted as enables
    // so the pad enable comes straight from a flop
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bidir_port_first_o.oe <= ~NMP_DIR_RESET; // RULE_11
        end else if (first_port_dir_wr_i) begin
            bidir_port_first_o.oe <= ~first_port_dir_i;
        end
    end

    // ==========================================================
    // second port direction mask, same all-inputs default
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bidir_port_second_o.oe <= ~NMP_DIR_RESET;
        end else if (second_port_dir_wr_i) begin
            bidir_port_second_o.oe <= ~second_port_dir_i;
        end
    end

    // ==========================================================
    // completion pulse for the fetch side
    always_ff @(posedge clock_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            exec_done_o <= 1'b0;
        end else begin
            exec_done_o <= (dec != NMP_DEC_NONE);
        end
    end

endmodule

// ===== test/nmp_pin_model.sv
// pin model: pad level of the two-way ports as seen from outside the core
`timescale 1ns/1ps
module nmp_pin_model
    import nmp_pkg::*;
(
    input wire nmp_pkg::nmp_bidir_s bidir_first_i,
    input wire nmp_pkg::nmp_bidir_s bidir_second_i,
    input wire logic [3:0] ext_first_i,
    input wire logic [3:0] ext_second_i,
    output logic [3:0] pin_first_o,
    output logic [3:0] pin_second_o
);
    // ==========================================================
    // driven bits follow the latch, released bits follow the outside driver
    assign pin_first_o = (bidir_first_i.oe & bidir_first_i.dout) |
        (~bidir_first_i.oe & ext_first_i);
    assign pin_second_o = (bidir_second_i.oe & bidir_second_i.dout) |
        (~bidir_second_i.oe & ext_second_i);
endmodule

// ===== test/nmp_exec_checker.sv
// checker: port-level timing relations of the nibble move executor
`timescale 1ns/1ps
module nmp_exec_checker
    import nmp_pkg::*;
(
    input wire logic clock_i,
    input wire logic rst_b_i,
    input wire nmp_pkg::nmp_instr_s instr_i,
    input wire logic [3:0] input_port_first_pin_i,
    input wire logic first_port_dir_wr_i,
    input wire logic [3:0] first_port_dir_i,
    input wire nmp_pkg::nmp_bidir_s bidir_port_first_o,
    input wire nmp_pkg::nmp_bidir_s bidir_port_second_o,
    input wire logic [3:0] led_output_port_o,
    input wire logic [3:0] arith_result_reg_o,
    input wire logic result_null_flag_o,
    input wire logic exec_done_o
);
    // ==========================================================
    // decode seen from the outside
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_b_i);
    logic rd;
    logic dec;
    logic [8:0] op;
    assign op = instr_i.word[15:7];
    assign rd = instr_i.valid && op inside {NMP_OP_RD_BIDIR1, NMP_OP_RD_BIDIR2,
        NMP_OP_RD_INPUT1, NMP_OP_RD_INPUT2};
    assign dec = rd || (instr_i.valid && (op inside {NMP_OP_STORE_ACCUM, NMP_OP_WR_BIDIR1,
        NMP_OP_WR_BIDIR2, {1'b0, NMP_OP_WR_LED}} || op[8:4] == {1'b0, NMP_OP_WREG} ||
        op[8:4] == NMP_OP_IMM));
    // ==========================================================
    // assertions
    a_done_after_op: assert property (dec |=> exec_done_o) else $error("no done");
    a_done_has_cause: assert property (exec_done_o |-> $past(dec)) else $error("stray done");
    // pins reach the core through two sync stages
    a_accum_from_pin: assert property (instr_i.valid && op == NMP_OP_RD_INPUT1 |=>
        arith_result_reg_o == $past(input_port_first_pin_i, 3)) else $error("accumulator bad");
    a_zero_flag_set: assert property (rd |=>
        result_null_flag_o == (arith_result_reg_o == 4'h0)) else $error("flag bad");
    a_flag_accum_held: assert property (!rd |=> $stable(result_null_flag_o) &&
        $stable(arith_result_reg_o)) else $error("accumulator or flag moved");
    a_led_cause: assert property ($changed(led_output_port_o) |->
        $past(instr_i.valid && op == {1'b0, NMP_OP_WR_LED})) else $error("led moved");
    a_port1_cause: assert property ($changed(bidir_port_first_o.dout) |->
        $past(instr_i.valid && op == NMP_OP_WR_BIDIR1)) else $error("port1 moved");
    a_port2_cause: assert property ($changed(bidir_port_second_o.dout) |->
        $past(instr_i.valid && op == NMP_OP_WR_BIDIR2)) else $error("port2 moved");
    a_dir_load: assert property (first_port_dir_wr_i |=>
        bidir_port_first_o.oe == ~$past(first_port_dir_i)) else $error("dir not loaded");
    a_dir_hold: assert property (!first_port_dir_wr_i |=>
        $stable(bidir_port_first_o.oe)) else $error("dir moved");
    c_read_zero: cover property (rd ##1 result_null_flag_o);
    c_led_write: cover property ($changed(led_output_port_o));
    c_dir_write: cover property (first_port_dir_wr_i);
endmodule

bind nmp_exec nmp_exec_checker i_nmp_exec_checker (
    .clock_i(clock_i),
    .rst_b_i(rst_b_i),
    .instr_i(instr_i),
    .input_port_first_pin_i(input_port_first_pin_i),
    .first_port_dir_wr_i(first_port_dir_wr_i),
    .first_port_dir_i(first_port_dir_i),
    .bidir_port_first_o(bidir_port_first_o),
    .bidir_port_second_o(bidir_port_second_o),
    .led_output_port_o(led_output_port_o),
    .arith_result_reg_o(arith_result_reg_o),
    .result_null_flag_o(result_null_flag_o),
    .exec_done_o(exec_done_o)
);

// ===== test/nmp_exec_tb.sv
// testbench: directed scenarios for the nibble move executor
`timescale 1ns/1ps
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin err_total++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, (g), (e)); end end
module nmp_exec_tb;
    import nmp_pkg::*;
    logic clock_i, rst_b_i, dw1, dw2, nul, done;
    logic [3:0] p1, p2, i1, i2, ext1, ext2, dm1, dm2, led, res;
    nmp_instr_s instr;
    nmp_bidir_s b1, b2;
    int err_total, num_checks;
    nmp_exec i_nmp_exec (.clock_i(clock_i), .rst_b_i(rst_b_i), .instr_i(instr),
        .bidir_port_first_pin_i(p1), .bidir_port_second_pin_i(p2),
        .input_port_first_pin_i(i1), .input_port_second_pin_i(i2),
        .first_port_dir_wr_i(dw1), .first_port_dir_i(dm1), .second_port_dir_wr_i(dw2),
        .second_port_dir_i(dm2), .bidir_port_first_o(b1), .bidir_port_second_o(b2),
        .led_output_port_o(led), .arith_result_reg_o(res), .result_null_flag_o(nul),
        .exec_done_o(done));
    nmp_pin_model i_nmp_pin_model (.bidir_first_i(b1), .bidir_second_i(b2),
        .ext_first_i(ext1), .ext_second_i(ext2), .pin_first_o(p1), .pin_second_o(p2));
    // ==========================================================
    // bus steps, all on the falling edge
    task exe(input logic [15:0] w);
        @(negedge clock_i);
        instr = {1'b1, w};
    endtask
    task idle;
        @(negedge clock_i);
        instr.valid = 1'b0;
    endtask
    // ram is not visible, so read it back through the led latch
    task led_is(input logic [6:0] a, input logic [3:0] e);
        exe({1'b0, NMP_OP_WR_LED, a});
        idle();
        `CHK(led, e)
    endtask
    // ==========================================================
    // scenarios
    task t_reads;
        logic [8:0] ops [4];
        logic [3:0] v [4];
        ops = '{NMP_OP_RD_BIDIR1, NMP_OP_RD_BIDIR2, NMP_OP_RD_INPUT1, NMP_OP_RD_INPUT2};
        v = '{4'h0, 4'h5, 4'h0, 4'ha};
        ext1 = v[0];
        ext2 = v[1];
        i1 = v[2];
        i2 = v[3];
        repeat (3) @(negedge clock_i);
        for (int k = 0; k < 4; k++) begin
            exe({ops[k], 7'h20 + 7'(k)});
            idle();
            `CHK({done, res, nul}, {1'b1, v[k], v[k] == 4'h0})
            led_is(7'h20 + 7'(k), v[k]);
        end
    endtask
    task t_moves;
        exe({NMP_OP_STORE_ACCUM, 7'h40});
        exe({NMP_OP_IMM, 4'h9, 7'h03});
        exe({1'b0, NMP_OP_WREG, 4'h3, 7'h7f});
        idle();
        `CHK({res, nul, done}, {4'ha, 1'b0, 1'b1})
        led_is(7'h40, 4'ha);
        led_is(7'h7f, 4'h9);
    endtask
    task t_outs;
        dw1 = 1'b1;
        dm1 = 4'h0;
        dw2 = 1'b1;
        dm2 = 4'h0;
        @(negedge clock_i);
        dw1 = 1'b0;
        dw2 = 1'b0;
        `CHK(b1.oe, 4'hf)
        `CHK(b2.oe, 4'hf)
        exe({NMP_OP_WR_BIDIR1, 7'h7f});
        exe({NMP_OP_WR_BIDIR2, 7'h40});
        idle();
        `CHK(b1.dout, 4'h9)
        `CHK(b2.dout, 4'ha)
        repeat (3) @(negedge clock_i);
        exe({NMP_OP_RD_BIDIR1, 7'h50});
        exe(16'h0000);
        idle();
        `CHK({res, done}, {4'h9, 1'b0})
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        clock_i = 1'b0;
        forever #2.5 clock_i = ~clock_i;
    end
    initial begin
        #5000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        {rst_b_i, dw1, dw2, dm1, dm2, i1, i2, ext1, ext2} = '0;
        instr = '0;
        err_total = 0;
        num_checks = 0;
        repeat (2) @(negedge clock_i);
        rst_b_i = 1'b1;
        `CHK({b1, b2, led, res, nul, done}, 26'h0000000)
        t_reads();
        t_moves();
        t_outs();
        tally_and_finish();
    end
endmodule
